// ===== rtl/acp_cfg.svh
// Register map, field positions, codes and reset values of the control block.
// Assumes a 32-bit classic Wishbone slave with byte addresses on an 8-bit bus.
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ACP_A_MODE  8'h00
`define ACP_A_STAT  8'h04
`define ACP_A_DATA  8'h08
`define ACP_A_OFF   8'h0C
`define ACP_A_FS    8'h10
`define ACP_A_GPO   8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACP_M_MD    2:0
`define ACP_M_PAR   3
`define ACP_M_APP   4
`define ACP_M_CHOP  5
`define ACP_M_SINC3 6
`define ACP_M_HIG   7
`define ACP_M_RATE  17:8
`define ACP_M_W     18
`define ACP_S_NRDY  7
`define ACP_S_ERR   6
`define ACP_S_NO_REFERENCE_FLAG 5
`define ACP_S_PAR   4
`define ACP_G_LVL   3:0
`define ACP_G_LOEN  4
`define ACP_G_HIEN  5

// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define ACP_MD_CONT 3'h0
`define ACP_MD_IDLE 3'h2
`define ACP_MD_PDN  3'h3
`define ACP_MD_IZS  3'h4
`define ACP_MD_IFS  3'h5
`define ACP_MD_SZS  3'h6
`define ACP_MD_SFS  3'h7

// ----------------------------------------
// Reset values and settling counts (output periods)
// ----------------------------------------
`define ACP_MODE_RST  18'h00002
`define ACP_FS_RST    24'h800000
`define ACP_FS_SHIFT  23
`define ACP_SET_CHOP  4'h2
`define ACP_SET_SINC3 4'h3
`define ACP_SET_SINC4 4'h4

`endif

// ===== rtl/acp_pkg.sv
// Types shared by the converter control block and its bench.
// Assumes constants come from acp_cfg.svh.
package acp_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } acp_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } acp_wb_rsp_t;

  typedef struct packed {
    logic [3:0] lvl;
    logic [3:0] oe_n;
  } acp_gpo_t;

  typedef enum logic [1:0] {SQ_IDLE, SQ_CONV, SQ_CAL} acp_seq_t;

  typedef enum logic [1:0] {IN_PINS, IN_ZERO, IN_FULL} acp_insel_t;

endpackage

// ===== rtl/acp_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes one clock domain; outputs reset low.
`timescale 1ns/100ps
module acp_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pin,
  output logic [W-1:0]      o_lvl
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } acp_sync_st_t;

  acp_sync_st_t q;
  acp_sync_st_t d;

  // A rise is taken only once the second and third stages are both high; any disagreement clears the level
  always_comb begin
    d     = q;
    d.s1  = i_pin;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.lvl = (q.s2 & q.s3) | (q.lvl & ~(q.s2 ^ q.s3));
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_lvl = q.lvl;

endmodule

// ===== rtl/acp_ctrl.sv
// Converter control: output pins, read parity, calibration sequencer, scaling.
// Assumes a classic Wishbone master and a filter strobe on i_fadc_clk whose
// rising edge marks one output period, with i_conv_raw stable around it.
`timescale 1ns/100ps
module acp_ctrl (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  input  wire acp_pkg::acp_wb_req_t i_wb,
  output acp_pkg::acp_wb_rsp_t      o_wb,
  input  wire logic [3:0]           i_gp_pin,
  input  wire logic                 i_fadc_clk,
  input  wire logic [23:0]          i_conv_raw,
  input  wire logic                 i_no_ref,
  input  wire logic                 i_cs_n,
  output acp_pkg::acp_gpo_t         o_gp,
  output logic                      o_dout_rdy,
  output acp_pkg::acp_insel_t       o_in_sel
);
  import acp_pkg::*;
  `include "acp_cfg.svh"

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [17:0] mode;
    logic [5:0]  gpo;
    logic [23:0] off;
    logic [23:0] fsc;
    logic [23:0] data;
    logic        nrdy;
    logic        err;
    logic        par;
    logic        calbad;
    acp_seq_t    seq;
    logic [2:0]  cal_md;
    logic [3:0]  cnt;
    logic        fadc_prev;
    acp_wb_rsp_t wb;
    acp_gpo_t    gp;
    logic        rdy_pin;
    acp_insel_t  insel;
  } acp_ctrl_st_t;

  acp_ctrl_st_t q;
  acp_ctrl_st_t d;
  logic [6:0]   lvl;
  logic [3:0]   pin_lvl;
  logic         fadc_lvl;
  logic         no_reference_flag;
  logic         cs_n_lvl;
  logic         wr;
  logic         rd;
  logic         mwr;
  logic         tick;
  logic         cfg_ok;
  logic [23:0]  res;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Settling time in output periods for a calibration code
  function automatic logic [3:0] cal_len(input logic [2:0] md, input logic chop,
                                         input logic sinc3, input logic hig);
    logic [3:0] s;
    s = chop ? `ACP_SET_CHOP : (sinc3 ? `ACP_SET_SINC3 : `ACP_SET_SINC4);
    if (md == `ACP_MD_IFS && hig) begin
      s = {s[2:0], 1'h0};
    end
    return s;
  endfunction

  // Offset first, then gain; the coefficient is unsigned with unity at 2^23
  function automatic logic [23:0] scale(input logic [23:0] raw, input logic [23:0] off,
                                        input logic [23:0] fs);
    logic [23:0] dif;
    logic [47:0] p;
    dif = raw - off;
    p   = {24'h0, dif} * {24'h0, fs};
    return p[`ACP_FS_SHIFT +: 24];
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  acp_sync3 #(
    .W (7)
  ) u_sync (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_pin  ({i_gp_pin, i_fadc_clk, i_no_ref, i_cs_n}),
    .o_lvl  (lvl)
  );

  assign pin_lvl  = lvl[6:3];
  assign fadc_lvl = lvl[2];
  assign no_reference_flag    = lvl[1];
  assign cs_n_lvl = lvl[0];

  assign wr     = i_wb.cyc && i_wb.stb && i_wb.we && !q.wb.ack;
  assign rd     = i_wb.cyc && i_wb.stb && !i_wb.we && !q.wb.ack;
  assign mwr    = wr && i_wb.adr == `ACP_A_MODE && i_wb.sel == 4'hF;
  assign tick   = fadc_lvl && !q.fadc_prev;
  assign cfg_ok = q.mode[`ACP_M_MD] == `ACP_MD_IDLE || q.mode[`ACP_M_MD] == `ACP_MD_PDN;
  assign res    = scale(i_conv_raw, q.off, q.fsc);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] nm;
    nm          = 32'h0;
    d           = q;
    d.wb.ack    = rd | wr;
    d.wb.dat    = 32'h0;
    d.fadc_prev = fadc_lvl;

    unique case (q.seq)
      SQ_IDLE: begin
        d.seq = SQ_IDLE;
      end
      SQ_CONV: begin
        if (tick) begin
          d.data = res;
          d.nrdy = 1'h0;
          d.par  = q.mode[`ACP_M_PAR] & (^res);
        end
      end
      SQ_CAL: begin
        if (no_reference_flag) begin
          d.calbad = 1'h1;
        end
        if (tick) begin
          if (q.cnt > 4'h1) begin
            d.cnt = q.cnt - 4'h1;
          end else begin
            if (q.calbad || no_reference_flag) begin
              d.err = 1'h1;
            end else if (q.cal_md == `ACP_MD_IZS || q.cal_md == `ACP_MD_SZS) begin
              d.off = i_conv_raw;
            end else begin
              d.fsc = i_conv_raw - q.off;
            end
            d.nrdy             = 1'h0;
            d.mode[`ACP_M_MD]  = `ACP_MD_IDLE;
            d.seq              = SQ_IDLE;
          end
        end
      end
    endcase

    // Bus writes come last so a new mode always overrides the sequencer
    if (wr) begin
      case (i_wb.adr)
        `ACP_A_MODE: begin
          nm     = wmerge({14'h0, q.mode}, i_wb.dat, i_wb.sel);
          d.mode = nm[`ACP_M_W-1:0];
          if (nm[2]) begin
            d.seq    = SQ_CAL;
            d.cal_md = nm[`ACP_M_MD];
            d.cnt    = cal_len(nm[`ACP_M_MD], nm[`ACP_M_CHOP], nm[`ACP_M_SINC3],
                               nm[`ACP_M_HIG]);
            d.nrdy   = 1'h1;
            d.err    = 1'h0;
            d.calbad = 1'h0;
          end else if (nm[`ACP_M_MD] == `ACP_MD_CONT) begin
            d.seq = SQ_CONV;
          end else begin
            d.seq = SQ_IDLE;
          end
        end
        `ACP_A_OFF: begin
          if (cfg_ok) begin
            nm    = wmerge({8'h0, q.off}, i_wb.dat, i_wb.sel);
            d.off = nm[23:0];
          end
        end
        `ACP_A_FS: begin
          if (cfg_ok) begin
            nm    = wmerge({8'h0, q.fsc}, i_wb.dat, i_wb.sel);
            d.fsc = nm[23:0];
          end
        end
        `ACP_A_GPO: begin
          nm    = wmerge({26'h0, q.gpo}, i_wb.dat, i_wb.sel);
          d.gpo = nm[5:0];
        end
        default: begin
          nm = 32'h0;
        end
      endcase
    end

    if (rd) begin
      case (i_wb.adr)
        `ACP_A_MODE: begin
          d.wb.dat[`ACP_M_W-1:0] = q.mode;
        end
        `ACP_A_STAT: begin
          d.wb.dat[`ACP_S_NRDY]  = q.nrdy;
          d.wb.dat[`ACP_S_ERR]   = q.err;
          d.wb.dat[`ACP_S_NO_REFERENCE_FLAG] = no_reference_flag;
          d.wb.dat[`ACP_S_PAR]   = q.par;
        end
        `ACP_A_DATA: begin
          d.wb.dat[23:0] = q.data;
          // A conversion landing in the same cycle keeps its ready state
          if (q.seq == SQ_IDLE || (q.seq == SQ_CONV && !tick)) begin
            d.nrdy = 1'h1;
          end
        end
        `ACP_A_OFF: begin
          d.wb.dat[23:0] = q.off;
        end
        `ACP_A_FS: begin
          d.wb.dat[23:0] = q.fsc;
        end
        `ACP_A_GPO: begin
          d.wb.dat[`ACP_G_LVL]  = pin_lvl;
          d.wb.dat[`ACP_G_LOEN] = q.gpo[`ACP_G_LOEN];
          d.wb.dat[`ACP_G_HIEN] = q.gpo[`ACP_G_HIEN];
        end
        default: begin
          d.wb.dat = 32'h0;
        end
      endcase
    end

    // Pins follow the register one cycle later
    d.gp.lvl  = q.gpo[`ACP_G_LVL];
    d.gp.oe_n = ~{{2{q.gpo[`ACP_G_HIEN]}}, {2{q.gpo[`ACP_G_LOEN]}}};
    // Ready pin only falls while the chip is selected
    d.rdy_pin = d.nrdy | cs_n_lvl;
    d.insel   = IN_PINS;
    if (d.seq == SQ_CAL && d.cal_md == `ACP_MD_IZS) begin
      d.insel = IN_ZERO;
    end else if (d.seq == SQ_CAL && d.cal_md == `ACP_MD_IFS) begin
      d.insel = IN_FULL;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      q         <= '0;
      q.mode    <= `ACP_MODE_RST;
      q.fsc     <= `ACP_FS_RST;
      q.gp.oe_n <= 4'hF;
      q.rdy_pin <= 1'h1;
    end else begin
      q <= d;
    end
  end

  assign o_wb       = q.wb;
  assign o_gp       = q.gp;
  assign o_dout_rdy = q.rdy_pin;
  assign o_in_sel   = q.insel;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  gp_pairs_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (q.gpo[`ACP_G_HIEN] && !q.gpo[`ACP_G_LOEN]) |=> o_gp.oe_n == 4'h3)
    else $error("output pair enables not honoured");

  gp_level_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ##1 1'h1 |-> o_gp.lvl == $past(q.gpo[`ACP_G_LVL]))
    else $error("output pin level differs from register");

  gp_readback_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (rd && i_wb.adr == `ACP_A_GPO) |=> o_wb.ack && o_wb.dat[3:0] == $past(pin_lvl))
    else $error("pin read-back wrong");

  par_off_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (q.seq == SQ_CONV && tick && !q.mode[`ACP_M_PAR]) |=> !q.par)
    else $error("parity set while disabled");

  par_even_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (q.seq == SQ_CONV && tick && q.mode[`ACP_M_PAR]) |=> !(^{q.data, q.par}))
    else $error("parity not even");

  scale_res_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (q.seq == SQ_CONV && tick) |=> q.data == $past(res) && !q.nrdy)
    else $error("stored result not scaled");

  cal_start_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (mwr && i_wb.dat[2]) |=> (q.seq == SQ_CAL && q.nrdy) ##1 o_dout_rdy)
    else $error("calibration start not flagged");

  cal_done_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (q.seq == SQ_CAL ##1 q.seq == SQ_IDLE) |-> !q.nrdy && q.mode[2:0] == `ACP_MD_IDLE)
    else $error("calibration end not reported");

  insel_full_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (mwr && i_wb.dat[2:0] == `ACP_MD_IFS) |=> o_in_sel == IN_FULL)
    else $error("internal full-scale input not routed");

  len_zero_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (mwr && (i_wb.dat[2:0] == `ACP_MD_IZS || i_wb.dat[2:0] == `ACP_MD_SZS)
     && !i_wb.dat[`ACP_M_CHOP] && !i_wb.dat[`ACP_M_SINC3]) |=> q.cnt == 4'h4)
    else $error("zero-scale length wrong");

  len_chop_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (mwr && i_wb.dat[2:0] == `ACP_MD_IZS && i_wb.dat[`ACP_M_CHOP]) |=> q.cnt == 4'h2)
    else $error("chopped zero-scale length wrong");

  len_gain_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (mwr && i_wb.dat[2:0] == `ACP_MD_IFS && !i_wb.dat[`ACP_M_CHOP]
     && !i_wb.dat[`ACP_M_SINC3] && i_wb.dat[`ACP_M_HIG]) |=> q.cnt == 4'h8)
    else $error("full-scale length at high gain wrong");

  len_sys_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (mwr && i_wb.dat[2:0] == `ACP_MD_SFS && !i_wb.dat[`ACP_M_CHOP]
     && i_wb.dat[`ACP_M_SINC3]) |=> q.cnt == 4'h3)
    else $error("system full-scale length wrong");

  coef_lock_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (wr && i_wb.adr == `ACP_A_OFF && !cfg_ok && q.seq != SQ_CAL) |=> $stable(q.off))
    else $error("offset written outside idle");

  no_reference_flag_err_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (q.seq == SQ_CAL && tick && q.cnt == 4'h1 && no_reference_flag)
    |=> q.err && $stable(q.off) && $stable(q.fsc))
    else $error("coefficient updated without reference");

endmodule

// ===== verif/acp_far_model.sv
// Far-side model: filter strobe with its raw result, and the four output pins.
// Assumes the bench changes i_raw only while i_run is low.
`timescale 1ns/100ps
module acp_far_model (
  input  wire logic              i_mclk,
  input  wire logic              i_run,
  input  wire logic [23:0]       i_raw,
  input  wire acp_pkg::acp_gpo_t i_gp,
  input  wire logic [3:0]        i_short,
  output logic                   o_fclk,
  output logic [23:0]            o_raw,
  output logic [3:0]             o_pin
);
  import acp_pkg::*;
  logic tgl;
  // --------------------------------
  // Filter strobe
  // --------------------------------
  // Stands still low between frames; 7 ns offset keeps it unrelated to i_mclk
  // Each restart begins from low, as the filter does after a sync restart
  initial begin
    o_fclk = 1'b0;
    #7;
    forever begin
      #200;
      o_fclk = i_run ? ~o_fclk : 1'b0;
    end
  end
  assign o_raw = i_raw;
  // --------------------------------
  // Pins
  // --------------------------------
  initial tgl = 1'b0;
  always @(posedge i_mclk) tgl <= ~tgl;
  // An undriven pin floats, so it shows a level that changes every cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_pin[i] = i_gp.oe_n[i] ? tgl : (i_gp.lvl[i] & ~i_short[i]);
    end
  end
endmodule

// ===== verif/acp_ctrl_tb.sv
// Self-checking bench for the converter control block.
// Assumes a classic Wishbone slave answering one edge after the take.
`timescale 1ns/100ps
`include "acp_cfg.svh"
module acp_ctrl_tb;
  import acp_pkg::*;
  typedef struct packed {
    logic [2:0]  md;
    logic [2:0]  cfg;
    logic [23:0] raw;
    logic [7:0]  adr;
    logic [23:0] coef;
  } acp_cal_t;
  logic        mclk;
  logic        rst;
  acp_wb_req_t wb_req;
  acp_wb_rsp_t wb_rsp;
  logic [3:0]  gp_pin;
  logic        fclk;
  logic [23:0] raw;
  logic [23:0] conv_raw;
  logic        no_ref;
  logic        cs_n;
  acp_gpo_t    gp;
  logic        dout_rdy;
  acp_insel_t  in_sel;
  logic        run;
  logic [3:0]  short_m;
  logic        counting;
  logic [31:0] d;
  logic [31:0] s;
  int          num_errors;
  int          total_checks;
  int          ticks;
  acp_cal_t    cal_tab [7];
  logic [24:0] cv_tab [3];

  acp_ctrl u_dut (.i_mclk(mclk), .i_rst(rst), .i_wb(wb_req), .o_wb(wb_rsp),
    .i_gp_pin(gp_pin), .i_fadc_clk(fclk), .i_conv_raw(conv_raw), .i_no_ref(no_ref),
    .i_cs_n(cs_n), .o_gp(gp), .o_dout_rdy(dout_rdy), .o_in_sel(in_sel));
  acp_far_model u_far (.i_mclk(mclk), .i_run(run), .i_raw(raw), .i_gp(gp),
    .i_short(short_m), .o_fclk(fclk), .o_raw(conv_raw), .o_pin(gp_pin));

  always #25 mclk = ~mclk;
  // Edges after completion are not part of the calibration
  always @(posedge fclk) if (counting && dout_rdy === 1'b1) ticks++;

  // --------------------------------
  // Checks and bus cycles
  // --------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fail_to(input string nm);
    num_errors++;
    $display("FAIL %s expected done seen timeout", nm);
    end_sim();
  endtask
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                         output logic [31:0] rd);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: wd};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    rd = wb_rsp.dat;
    wb_req <= '0;
    if (n >= 50) fail_to("bus ack");
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] j;
    wb_xfer(1'b1, a, wd, j);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    wb_xfer(1'b0, a, 32'h0, v);
  endtask
  // Strobe is stopped and in-flight ticks are let land before returning
  task automatic poll_ready();
    logic [31:0] v;
    int n;
    v = 32'hFF;
    for (n = 0; n < 100 && v[7] !== 1'b0; n++) rd(`ACP_A_STAT, v);
    if (n >= 100) fail_to("status ready");
    run <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  task automatic wait_pin_low();
    int n;
    for (n = 0; n < 400 && dout_rdy !== 1'b0; n++) @(posedge mclk);
    if (n >= 400) fail_to("ready pin");
    run <= 1'b0;
    counting = 1'b0;
  endtask
  function automatic logic [7:0] exp_ticks(input logic [2:0] md, input logic [2:0] cfg);
    logic [3:0] b;
    b = cfg[0] ? `ACP_SET_CHOP : (cfg[1] ? `ACP_SET_SINC3 : `ACP_SET_SINC4);
    return (md == `ACP_MD_IFS && cfg[2]) ? {3'h0, b, 1'b0} : {4'h0, b};
  endfunction
  function automatic acp_insel_t exp_sel(input logic [2:0] md);
    return (md == `ACP_MD_IZS) ? IN_ZERO : ((md == `ACP_MD_IFS) ? IN_FULL : IN_PINS);
  endfunction
  // Coefficients left by the calibrations: offset 0x18, full scale 0x200000
  function automatic logic [23:0] scale(input logic [23:0] r);
    logic [47:0] p;
    p = ({24'h0, r} - 48'h18) * 48'h200000;
    return p[46:23];
  endfunction

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    wb_req = '0;
    no_ref = 1'b0;
    cs_n = 1'b0;
    run = 1'b0;
    raw = 24'h0;
    short_m = 4'h0;
    counting = 1'b0;
    num_errors = 0;
    total_checks = 0;
    ticks = 0;
    cal_tab = '{'{`ACP_MD_IZS, 3'b000, 24'h000020, `ACP_A_OFF, 24'h000020},
                '{`ACP_MD_SZS, 3'b010, 24'h000030, `ACP_A_OFF, 24'h000030},
                '{`ACP_MD_IZS, 3'b001, 24'h000010, `ACP_A_OFF, 24'h000010},
                '{`ACP_MD_SZS, 3'b001, 24'h000018, `ACP_A_OFF, 24'h000018},
                '{`ACP_MD_IFS, 3'b000, 24'h400018, `ACP_A_FS, 24'h400000},
                '{`ACP_MD_IFS, 3'b100, 24'h600018, `ACP_A_FS, 24'h600000},
                '{`ACP_MD_SFS, 3'b010, 24'h200018, `ACP_A_FS, 24'h200000}};
    cv_tab = '{{1'b1, 24'h000418}, {1'b1, 24'h00041C}, {1'b0, 24'h000418}};
    repeat (6) @(posedge mclk);
    // Reset values are checked while reset still holds them steady
    chk_pin("oe_n reset", 8'h0F, {4'h0, gp.oe_n});
    chk_pin("ready pin reset", 8'h01, {7'h0, dout_rdy});
    rst <= 1'b0;
    @(posedge mclk);
    rd(`ACP_A_MODE, d); chk_reg("mode reset", {14'h0, `ACP_MODE_RST}, d);
    rd(`ACP_A_FS, d); chk_reg("fullscale reset", {8'h0, `ACP_FS_RST}, d);
    rd(`ACP_A_OFF, d); chk_reg("offset reset", 32'h0, d);
    rd(8'h1C, d); chk_reg("unmapped", 32'h0, d);
    wr(`ACP_A_OFF, 32'h000000AB);
    rd(`ACP_A_OFF, d); chk_reg("offset idle write", 32'h000000AB, d);
    // Lower pair with pin 0 shorted low, then upper pair alone
    short_m <= 4'h1;
    wr(`ACP_A_GPO, 32'h0000001D);
    repeat (8) @(posedge mclk);
    chk_pin("gp oe_n lower", 8'h0C, {4'h0, gp.oe_n});
    chk_pin("gp lvl lower", 8'h01, {6'h0, gp.lvl[1:0]});
    rd(`ACP_A_GPO, d); chk_reg("gp read lower", 32'h10, d & 32'h33);
    short_m <= 4'h0;
    wr(`ACP_A_GPO, 32'h0000002A);
    repeat (8) @(posedge mclk);
    chk_pin("gp oe_n upper", 8'h03, {4'h0, gp.oe_n});
    chk_pin("gp lvl upper", 8'h02, {6'h0, gp.lvl[3:2]});
    rd(`ACP_A_GPO, d); chk_reg("gp read upper", 32'h28, d & 32'h3C);
    // Zero-scale kinds first, rate word 96 is a multiple of 16
    foreach (cal_tab[k]) begin
      raw <= cal_tab[k].raw;
      wr(`ACP_A_MODE, {14'h0, 10'h060, cal_tab[k].cfg, 2'b00, cal_tab[k].md});
      chk_pin("cal ready pin", 8'h01, {7'h0, dout_rdy});
      chk_pin("cal input", {6'h0, exp_sel(cal_tab[k].md)}, {6'h0, in_sel});
      rd(`ACP_A_STAT, s); chk_reg("cal not ready", 32'h80, s & 32'h80);
      ticks = 0;
      counting = 1'b1;
      run <= 1'b1;
      wait_pin_low();
      chk_pin("cal ticks", exp_ticks(cal_tab[k].md, cal_tab[k].cfg), ticks[7:0]);
      rd(`ACP_A_STAT, s); chk_reg("cal status", 32'h0, s & 32'hC0);
      rd(`ACP_A_MODE, d); chk_reg("cal mode", {29'h0, `ACP_MD_IDLE}, d & 32'h7);
      rd(cal_tab[k].adr, d); chk_reg("coefficient", {8'h0, cal_tab[k].coef}, d);
      chk_pin("input after cal", {6'h0, IN_PINS}, {6'h0, in_sel});
    end
    wr(`ACP_A_MODE, {14'h0, 10'h060, 3'b000, 2'b11, `ACP_MD_CONT});
    wr(`ACP_A_OFF, 32'h00000555);
    rd(`ACP_A_OFF, d); chk_reg("offset write in conversion", 32'h18, d);
    foreach (cv_tab[k]) begin
      wr(`ACP_A_MODE, {14'h0, 10'h060, 3'b000, {2{cv_tab[k][24]}}, `ACP_MD_CONT});
      raw <= cv_tab[k][23:0];
      rd(`ACP_A_DATA, d);
      run <= 1'b1;
      poll_ready();
      rd(`ACP_A_DATA, d); chk_reg("data", {8'h0, scale(cv_tab[k][23:0])}, d);
      rd(`ACP_A_STAT, s);
      chk_reg("parity", {27'h0, cv_tab[k][24] & ^scale(cv_tab[k][23:0]), 4'h0}, s & 32'h10);
      if (cv_tab[k][24]) chk_pin("ones even", 8'h00, {7'h0, ^{d[23:0], s[4]}});
    end
    // Started straight from conversion, deselected, reference missing
    no_ref <= 1'b1;
    cs_n <= 1'b1;
    raw <= 24'h000077;
    wr(`ACP_A_MODE, {14'h0, 10'h060, 3'b001, 2'b00, `ACP_MD_IZS});
    run <= 1'b1;
    poll_ready();
    rd(`ACP_A_STAT, s); chk_reg("error status", 32'h60, s & 32'hE0);
    rd(`ACP_A_OFF, d); chk_reg("offset kept", 32'h18, d);
    chk_pin("ready pin deselected", 8'h01, {7'h0, dout_rdy});
    end_sim();
  end
endmodule
